// ===== adcoc_pkg.sv
// Constants, register map and carrier types for the converter output configuration registers
package adcoc_pkg;

	// Channel count and field widths
	localparam int NCH = 4;
	localparam int TRIM_W = 6;
	localparam int APB_AW = 12;
	localparam int APB_DW = 32;

	// Register indices as printed; byte address is four times the index
	localparam logic [9:0] IDX_CHAN_INDEX = 10'h005;
	localparam logic [9:0] IDX_OFFSET_TRIM = 10'h010;
	localparam logic [9:0] IDX_OUTPUT_CONFIG = 10'h014;
	localparam logic [9:0] IDX_DRIVE_LEVEL = 10'h015;
	localparam logic [9:0] IDX_REFERENCE_SPAN = 10'h018;
	localparam logic [9:0] IDX_LINK_PLL_RATE = 10'h021;
	localparam logic [9:0] IDX_SIGNATURE_LOW = 10'h024;
	localparam logic [9:0] IDX_UPDATE = 10'h0FF;

	// Field positions
	localparam int OC_OE_N_BIT = 4;
	localparam int OC_INV_BIT = 2;
	localparam int OC_FMT_LSB = 0;
	localparam int PLL_RATE_BIT = 3;
	localparam int UPD_XFER_BIT = 0;

	// Data format codes
	localparam logic [1:0] FMT_OFFSET_BIN = 2'h0;
	localparam logic [1:0] FMT_TWOS = 2'h1;
	localparam logic [1:0] FMT_GRAY = 2'h2;

	// Drive level codes: 400, 500, 440, 320 mV
	localparam logic [1:0] DRV_400MV = 2'h0;
	localparam logic [1:0] DRV_500MV = 2'h1;
	localparam logic [1:0] DRV_440MV = 2'h2;
	localparam logic [1:0] DRV_320MV = 2'h3;

	// Reference span codes: reset gives 1.25 V p-p, minimum 0.98 V p-p
	localparam logic [4:0] SPAN_1V25 = 5'h00;
	localparam logic [4:0] SPAN_MIN_0V98 = 5'h10;
	localparam logic [4:0] SPAN_1V23 = 5'h1F;

	// Reset values
	localparam logic [3:0] RST_CHAN_INDEX = 4'hF;
	localparam logic [5:0] RST_TRIM = 6'h00;
	localparam logic RST_OE_N = 1'b0;
	localparam logic RST_INVERT = 1'b0;
	localparam logic [1:0] RST_FMT = FMT_OFFSET_BIN;
	localparam logic [1:0] RST_DRIVE = DRV_400MV;
	localparam logic [4:0] RST_SPAN = SPAN_1V25;
	localparam logic [7:0] RST_LINK_PLL = 8'h08;
	localparam logic [7:0] RST_SIGNATURE = 8'h00;

	// Per-channel configuration
	typedef struct packed {
		logic [TRIM_W-1:0] trim;
		logic oe_n;
	} adcoc_chan_cfg_t;

	// Configuration shared by all channels
	typedef struct packed {
		logic invert;
		logic [1:0] fmt;
		logic [1:0] drive;
		logic [4:0] span;
		logic pll_high;
	} adcoc_shared_cfg_t;

	localparam adcoc_chan_cfg_t RST_CHAN_CFG = '{trim: RST_TRIM, oe_n: RST_OE_N};
	localparam adcoc_shared_cfg_t RST_SHARED_CFG = '{invert: RST_INVERT, fmt: RST_FMT, drive: RST_DRIVE,
		span: RST_SPAN, pll_high: RST_LINK_PLL[PLL_RATE_BIT]};

endpackage

// ===== adcoc_fmt.sv
// One channel output path: offset trim, format coding, invert and output enable
`timescale 1ns/100ps
module adcoc_fmt #(
	parameter int SW = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [SW-1:0] sample,
	input wire logic [adcoc_pkg::TRIM_W-1:0] trim,
	input wire logic oe_n_cfg,
	input wire logic invert,
	input wire logic [1:0] fmt,
	output logic [SW-1:0] data_out,
	output logic data_oe_n
);

	logic signed [SW+1:0] sum;
	logic [SW-1:0] sat;
	logic [SW-1:0] coded;

	// Trim as signed counts, saturated so the code never wraps end to end
	always_comb begin
		sum = $signed({2'h0, sample}) + $signed({{(SW-4){trim[adcoc_pkg::TRIM_W-1]}}, trim}); // R1
		if (sum < 0) begin
			sat = '0;
		end else if (sum > $signed({2'h0, {SW{1'b1}}})) begin
			sat = '1;
		end else begin
			sat = sum[SW-1:0];
		end
	end

	// Format coding, then optional inversion
	always_comb begin
		case (fmt)
			adcoc_pkg::FMT_TWOS: coded = {~sat[SW-1], sat[SW-2:0]}; // R4
			adcoc_pkg::FMT_GRAY: coded = sat ^ (sat >> 1); // R4
			default: coded = sat; // Unused code 11 falls back to offset binary
		endcase
		if (invert) begin
			coded = ~coded; // R3
		end
	end

	// Registered outputs; enable is low while the pins are driven
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_out <= '0;
			data_oe_n <= adcoc_pkg::RST_OE_N;
		end else begin
			data_out <= coded;
			data_oe_n <= oe_n_cfg; // R2
		end
	end

endmodule // adcoc_fmt

// ===== adcoc_regs.sv
// Output configuration register group with APB slave and per-channel output paths
//
// Contract
// R1 - Per-channel signed six-bit offset trim, -32..+31
// R2 - Output enable bar: 0 drives, 1 off
// R3 - Shared invert bit inverts output data
// R4 - Shared format: offset binary, twos, Gray
// R5 - Shared two-bit drive level code kept
// R6 - Shared five-bit reference span code kept
// R7 - PLL rate bit, resets high, default 0x08
// R8 - Read-only signature low byte, resets zero
// R9 - Per-channel writes go to indexed channels
// R10 - Transfer bit copies staged into active
// R11 - Signature writes ignored, unused bits zero
// R12 - Copy per channel, single shared copy
`timescale 1ns/100ps
module adcoc_regs #(
	parameter int SW = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [adcoc_pkg::APB_AW-1:0] paddr,
	input wire logic [adcoc_pkg::APB_DW-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [adcoc_pkg::APB_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [adcoc_pkg::NCH-1:0][SW-1:0] sample_in,
	input wire logic [adcoc_pkg::NCH-1:0][7:0] signature_in,
	output logic [adcoc_pkg::NCH-1:0][SW-1:0] data_out,
	output logic [adcoc_pkg::NCH-1:0] data_oe_n,
	output logic [1:0] drive_level_code,
	output logic [4:0] span_code,
	output logic pll_high_rate
);

	localparam int NCH = adcoc_pkg::NCH;

	// Staged (master) and active (slave) copies
	adcoc_pkg::adcoc_chan_cfg_t chan_stg_r [NCH];
	adcoc_pkg::adcoc_chan_cfg_t chan_act_r [NCH];
	adcoc_pkg::adcoc_shared_cfg_t shared_stg_r;
	adcoc_pkg::adcoc_shared_cfg_t shared_act_r;
	logic [NCH-1:0] chan_index_r;
	logic [7:0] sig_r [NCH];

	// Bus handshake state
	logic pready_r;
	logic pslverr_r;
	logic [adcoc_pkg::APB_DW-1:0] prdata_r;
	logic access;
	logic done;
	logic wr_en;
	logic [9:0] idx;
	logic [7:0] wbyte;
	logic [7:0] rd_byte;
	logic addr_hit;
	logic [1:0] rd_ch;

	// Index of the lowest selected channel; readback shows that one
	function automatic logic [1:0] lowest_sel(input logic [NCH-1:0] sel);
		logic [1:0] r;
		r = 2'h0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (sel[i]) begin
				r = i[1:0];
			end
		end
		return r;
	endfunction

	// True for every word this group answers
	function automatic logic mapped(input logic [9:0] i);
		case (i)
			adcoc_pkg::IDX_CHAN_INDEX,
			adcoc_pkg::IDX_OFFSET_TRIM,
			adcoc_pkg::IDX_OUTPUT_CONFIG,
			adcoc_pkg::IDX_DRIVE_LEVEL,
			adcoc_pkg::IDX_REFERENCE_SPAN,
			adcoc_pkg::IDX_LINK_PLL_RATE,
			adcoc_pkg::IDX_SIGNATURE_LOW,
			adcoc_pkg::IDX_UPDATE: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	// Address decode; misaligned addresses count as unmapped
	assign idx = paddr[adcoc_pkg::APB_AW-1:2];
	assign addr_hit = mapped(idx) && (paddr[1:0] == 2'h0);
	assign access = psel && penable;
	assign done = access && pready_r;
	assign wr_en = done && pwrite && pstrb[0] && addr_hit;
	assign wbyte = pwdata[7:0];
	assign rd_ch = lowest_sel(chan_index_r);

	// Read mux; unused bit positions read as zero
	always_comb begin
		rd_byte = 8'h00;
		case (idx)
			adcoc_pkg::IDX_CHAN_INDEX: rd_byte = {4'h0, chan_index_r};
			adcoc_pkg::IDX_OFFSET_TRIM: rd_byte = {2'h0, chan_stg_r[rd_ch].trim}; // R11
			adcoc_pkg::IDX_OUTPUT_CONFIG: begin
				rd_byte[adcoc_pkg::OC_OE_N_BIT] = chan_stg_r[rd_ch].oe_n;
				rd_byte[adcoc_pkg::OC_INV_BIT] = shared_stg_r.invert;
				rd_byte[adcoc_pkg::OC_FMT_LSB +: 2] = shared_stg_r.fmt;
			end
			adcoc_pkg::IDX_DRIVE_LEVEL: rd_byte = {6'h00, shared_stg_r.drive};
			adcoc_pkg::IDX_REFERENCE_SPAN: rd_byte = {3'h0, shared_stg_r.span};
			adcoc_pkg::IDX_LINK_PLL_RATE: rd_byte[adcoc_pkg::PLL_RATE_BIT] = shared_stg_r.pll_high;
			adcoc_pkg::IDX_SIGNATURE_LOW: rd_byte = sig_r[rd_ch]; // R8
			default: rd_byte = 8'h00; // Transfer bit acts at once and reads zero
		endcase
	end

	// One wait state: ready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
		end else begin
			pready_r <= access && !pready_r;
		end
	end

	// Read data and error are captured with ready so they stand together
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= '0;
			pslverr_r <= 1'b0;
		end else if (access && !pready_r) begin
			prdata_r <= (pwrite || !addr_hit) ? '0 : {24'h00_0000, rd_byte};
			pslverr_r <= !addr_hit;
		end else begin
			prdata_r <= '0;
			pslverr_r <= 1'b0;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	// Channel selection for the following per-channel writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_index_r <= adcoc_pkg::RST_CHAN_INDEX;
		end else if (wr_en && idx == adcoc_pkg::IDX_CHAN_INDEX) begin
			chan_index_r <= wbyte[NCH-1:0]; // R9
		end
	end

	// Staged per-channel fields, one copy per channel, written only where selected
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < NCH; c++) begin
				chan_stg_r[c] <= adcoc_pkg::RST_CHAN_CFG;
			end
		end else if (wr_en) begin
			for (int c = 0; c < NCH; c++) begin
				if (chan_index_r[c]) begin // R9 R12
					if (idx == adcoc_pkg::IDX_OFFSET_TRIM) begin
						chan_stg_r[c].trim <= wbyte[adcoc_pkg::TRIM_W-1:0]; // R1
					end
					if (idx == adcoc_pkg::IDX_OUTPUT_CONFIG) begin
						chan_stg_r[c].oe_n <= wbyte[adcoc_pkg::OC_OE_N_BIT]; // R2
					end
				end
			end
		end
	end

	// Staged shared fields, a single copy regardless of channel selection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shared_stg_r <= adcoc_pkg::RST_SHARED_CFG;
		end else if (wr_en) begin
			case (idx)
				adcoc_pkg::IDX_OUTPUT_CONFIG: begin
					shared_stg_r.invert <= wbyte[adcoc_pkg::OC_INV_BIT]; // R3
					shared_stg_r.fmt <= wbyte[adcoc_pkg::OC_FMT_LSB +: 2]; // R4
				end
				adcoc_pkg::IDX_DRIVE_LEVEL: shared_stg_r.drive <= wbyte[1:0]; // R5
				adcoc_pkg::IDX_REFERENCE_SPAN: shared_stg_r.span <= wbyte[4:0]; // R6
				adcoc_pkg::IDX_LINK_PLL_RATE: shared_stg_r.pll_high <= wbyte[adcoc_pkg::PLL_RATE_BIT]; // R7
				default: shared_stg_r <= shared_stg_r; // Signature write falls here and is dropped
			endcase
		end
	end

	// Transfer: everything staged goes live in one edge; data_out and data_oe_n follow one cycle after the shared analog codes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < NCH; c++) begin
				chan_act_r[c] <= adcoc_pkg::RST_CHAN_CFG;
			end
			shared_act_r <= adcoc_pkg::RST_SHARED_CFG;
		end else if (wr_en && idx == adcoc_pkg::IDX_UPDATE && wbyte[adcoc_pkg::UPD_XFER_BIT]) begin
			for (int c = 0; c < NCH; c++) begin
				chan_act_r[c] <= chan_stg_r[c]; // R10
			end
			shared_act_r <= shared_stg_r; // R10
		end
	end

	// Signature capture from the core, read-only to software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < NCH; c++) begin
				sig_r[c] <= adcoc_pkg::RST_SIGNATURE;
			end
		end else begin
			for (int c = 0; c < NCH; c++) begin
				sig_r[c] <= signature_in[c]; // R8 R11
			end
		end
	end

	// Shared analog codes leave straight from the active flops
	assign drive_level_code = shared_act_r.drive; // R5
	assign span_code = shared_act_r.span; // R6
	assign pll_high_rate = shared_act_r.pll_high; // R7

	// One output path per channel
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		adcoc_fmt #(
			.SW(SW)
		) u_fmt (
			.pclk(pclk),
			.presetn(presetn),
			.sample(sample_in[c]),
			.trim(chan_act_r[c].trim),
			.oe_n_cfg(chan_act_r[c].oe_n),
			.invert(shared_act_r.invert),
			.fmt(shared_act_r.fmt),
			.data_out(data_out[c]),
			.data_oe_n(data_oe_n[c])
		);
	end

endmodule // adcoc_regs

// ===== adcoc_regs_chk.sv
// Bus and configuration checks for the output configuration register group
`timescale 1ns/100ps
module adcoc_regs_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] data_oe_n,
	input wire logic [1:0] drive_level_code,
	input wire logic [4:0] span_code,
	input wire logic pll_high_rate
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Accepted transfer write to the update register
	logic upd;
	assign upd = psel && penable && pready && pwrite && paddr == 12'h3FC && pwdata[0] && pstrb[0];

	chk_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("answer not in second access cycle");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held over one cycle");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_rdata_idle: assert property (!pready |-> prdata == '0)
		else $error("read data outside answer");
	chk_rdata_upper: assert property (pready |-> prdata[31:8] == '0)
		else $error("unused read bits set");
	chk_sig_noerr: assert property (pready && paddr == 12'h090 |-> !pslverr)
		else $error("signature access flagged");
	chk_misalign_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == '0)
		else $error("misaligned access accepted");
	// Active copy moves only after a transfer request
	chk_shared_hold: assert property (!$past(upd) && !$past(upd, 2)
		|-> $stable({drive_level_code, span_code, pll_high_rate}))
		else $error("shared outputs moved without transfer");
	chk_oe_hold: assert property (!$past(upd) && !$past(upd, 2) |-> $stable(data_oe_n))
		else $error("output enable moved without transfer");

	cover property (upd);
	cover property (pready && pslverr);
	cover property (pready && !pwrite && paddr == 12'h090);
endmodule // adcoc_regs_chk

bind adcoc_regs adcoc_regs_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .data_oe_n(data_oe_n), .drive_level_code(drive_level_code), .span_code(span_code),
	.pll_high_rate(pll_high_rate));

// ===== test_adc_output_config_regs.sv
// Self-checking bench for the output configuration register group
`timescale 1ns/100ps
module test_adc_output_config_regs;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, pll_high_rate;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [3:0] pstrb, data_oe_n;
	logic [3:0][11:0] sample_in, data_out;
	logic [3:0][7:0] signature_in;
	logic [1:0] drive_level_code;
	logic [4:0] span_code;
	int fail_count, n_compared;

	adcoc_regs #(.SW(12)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sample_in(sample_in), .signature_in(signature_in), .data_out(data_out),
		.data_oe_n(data_oe_n), .drive_level_code(drive_level_code), .span_code(span_code),
		.pll_high_rate(pll_high_rate));

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Request held until ready is seen at an edge; no latency assumed
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) fail_count++;
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [11:0] code(input logic [11:0] v, input logic [1:0] f, input logic inv);
		logic [11:0] b;
		b = (f == 2'h1) ? {~v[11], v[10:0]} : (f == 2'h2) ? (v ^ (v >> 1)) : v;
		return inv ? ~b : b;
	endfunction

	task automatic t_reset();
		logic [11:0] a [7] = '{12'h014, 12'h040, 12'h050, 12'h054, 12'h060, 12'h084, 12'h090};
		logic [7:0] e [7] = '{8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00};
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, a[i], 32'h0);
			chk(rdat, e[i]);
		end
		chk({data_oe_n, drive_level_code, span_code, pll_high_rate}, 12'h001);
	endtask

	// Staged values stay invisible until the transfer bit
	task automatic t_stage();
		apb(1'b1, 12'h054, 32'h3);
		apb(1'b1, 12'h060, 32'h10);
		apb(1'b1, 12'h084, 32'h0);
		pstrb <= 4'hE;
		apb(1'b1, 12'h054, 32'h1);
		pstrb <= 4'hF;
		apb(1'b0, 12'h054, 32'h0);
		chk(rdat, 32'h3);
		chk({drive_level_code, span_code, pll_high_rate}, 8'h01);
		apb(1'b1, 12'h3FC, 32'h1);
		repeat (2) @(posedge pclk);
		chk({drive_level_code, span_code, pll_high_rate}, 8'hE0);
		apb(1'b0, 12'h3FC, 32'h0);
		chk(rdat, 32'h0);
	endtask

	// Trim at both ends of its range, every format with and without invert
	task automatic t_path();
		logic [3:0][11:0] v;
		v = {12'h123, 12'h800, 12'hFFF, 12'h000};
		apb(1'b1, 12'h014, 32'h1);
		apb(1'b1, 12'h040, 32'h20);
		apb(1'b1, 12'h014, 32'h2);
		apb(1'b1, 12'h040, 32'h1F);
		apb(1'b1, 12'h014, 32'hF);
		sample_in <= {12'h123, 12'h800, 12'hFF0, 12'h010};
		for (int m = 0; m < 6; m++) begin
			apb(1'b1, 12'h050, 32'(m % 2 * 4 + m / 2));
			apb(1'b1, 12'h3FC, 32'h1);
			repeat (3) @(posedge pclk);
			for (int c = 0; c < 4; c++) chk(data_out[c], code(v[c], 2'(m / 2), 1'(m % 2)));
		end
	endtask

	task automatic t_chan();
		apb(1'b1, 12'h014, 32'h2);
		apb(1'b1, 12'h050, 32'h10);
		apb(1'b1, 12'h3FC, 32'h1);
		repeat (2) @(posedge pclk);
		chk(data_oe_n, 4'h2);
		apb(1'b0, 12'h050, 32'h0);
		chk(rdat, 32'h10);
		apb(1'b1, 12'h014, 32'h1);
		apb(1'b0, 12'h050, 32'h0);
		chk(rdat, 32'h0);
	endtask

	task automatic t_err();
		signature_in <= {8'h44, 8'h33, 8'h22, 8'hA5};
		apb(1'b1, 12'h090, 32'hFF);
		chk(rerr, 1'b0);
		apb(1'b0, 12'h090, 32'h0);
		chk(rdat, 32'hA5);
		apb(1'b1, 12'h050, 32'hFFFF_FFFF);
		apb(1'b0, 12'h050, 32'h0);
		chk(rdat, 32'h17);
		apb(1'b1, 12'h054, 32'h2);
		apb(1'b1, 12'h3FC, 32'h1);
		repeat (3) @(posedge pclk);
		chk(data_out[0], 12'hFFF);
		chk(data_out[2], 12'h7FF);
		chk(data_oe_n, 4'h3);
		chk({drive_level_code, span_code, pll_high_rate}, 8'hA0);
		apb(1'b0, 12'h100, 32'h0);
		chk({rerr, rdat}, 33'h1_0000_0000);
		apb(1'b1, 12'h041, 32'h1);
		chk(rerr, 1'b1);
	endtask

	task automatic results();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge pclk);
		fail_count++;
		results();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hF;
		sample_in = '0;
		signature_in = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_stage();
		t_path();
		t_chan();
		t_err();
		results();
	end
endmodule // test_adc_output_config_regs
